// ===== core/pec_consts.svh
`ifndef PEC_CONSTS_SVH
`define PEC_CONSTS_SVH

// Clock rate of the logger clock
`define PEC_CLK_HZ 50000000
`define PEC_MS_PER_S 1000
// Contact bounce settling time, in milliseconds
`define PEC_DB_TIME_MS 5
`define PEC_DB_CYCLES (`PEC_CLK_HZ / `PEC_MS_PER_S * `PEC_DB_TIME_MS)
// Millisecond timebase for the pulse interval
`define PEC_MS_CYCLES (`PEC_CLK_HZ / `PEC_MS_PER_S)
`define PEC_MS_PER_HOUR 3600000

// Register byte offsets
`define PEC_OFS_CTRL 8'h00
`define PEC_OFS_CMD 8'h04
`define PEC_OFS_TOTAL 8'h08
`define PEC_OFS_QTY_RUN 8'h0C
`define PEC_OFS_QTY_LOG 8'h10
`define PEC_OFS_UPP 8'h14
`define PEC_OFS_INTERVAL 8'h18
`define PEC_OFS_RATE 8'h1C
`define PEC_OFS_QTY_UNITS 8'h20
`define PEC_OFS_IRQ_STAT 8'h24
`define PEC_OFS_IRQ_MASK 8'h28

// Field positions
`define PEC_CTRL_MIDNIGHT 0
`define PEC_CTRL_LOG_CHG 1
`define PEC_CMD_CLEAR 0
`define PEC_IRQ_PULSE 0
`define PEC_IRQ_LOGGED 1
`define PEC_IRQ_CHANGE 2
`define PEC_IRQ_WRAP 3
`define PEC_IRQ_RATE 4

// Reset values
`define PEC_CTRL_RST 2'h0
`define PEC_UPP_RST 32'h0001_0000
`define PEC_MASK_RST 5'h00

`endif

// ===== core/pec_pkg.sv
`default_nettype none

package pec_pkg;

  // Rate divider sequencing
  typedef enum logic [0:0] {
    DIV_IDLE = 1'b0,
    DIV_RUN = 1'b1
  } pec_div_st_t;

  // Debouncer state
  typedef struct packed {
    logic sync1;
    logic sync2;
    logic level;
    logic [19:0] cnt;
    logic pulse;
  } pec_db_st_t;

  // Counter core state, apart from the retained total
  typedef struct packed {
    logic [1:0] ctrl;
    logic [31:0] upp;
    logic [31:0] qty_run;
    logic [31:0] qty_log;
    logic [31:0] qty_units;
    logic [31:0] interval;
    logic [31:0] rate;
    logic [4:0] irq_stat;
    logic [4:0] irq_mask;
    logic [19:0] ms_div;
    logic [31:0] ms_since;
    logic have_prev;
    pec_div_st_t div_st;
    logic [53:0] div_num;
    logic [32:0] div_rem;
    logic [31:0] div_den;
    logic [5:0] div_cnt;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] hrdata;
    logic rdy;
    logic irq;
    logic wake;
    logic log_evt;
  } pec_st_t;

endpackage: pec_pkg

`default_nettype wire

// ===== core/pec_pulse_if.sv
`timescale 1ns/1ns
`default_nettype none

// Clean pulse from the debouncer to the counter core
interface pec_pulse_if;
  logic pulse;
  logic level;
  modport src (output pulse, output level);
  modport snk (input pulse, input level);
endinterface: pec_pulse_if

`default_nettype wire

// ===== core/pec_debounce.sv
`timescale 1ns/1ns
`default_nettype none
`include "pec_consts.svh"

module pec_debounce #(
  parameter int DB_CYCLES = `PEC_DB_CYCLES
) (
  input wire logic hclk, // Logger clock
  input wire logic hresetn, // Async reset, active low
  input wire logic clk_en, // Freezes state while low
  input wire logic pin_in, // Raw switch input
  pec_pulse_if.src pls // Clean closure pulse
);

  pec_pkg::pec_db_st_t q;
  pec_pkg::pec_db_st_t d;

  // Two-stage sync, then a level must hold a full settle time to count
  always_comb
  begin
    d = q;
    d.sync1 = pin_in;
    d.sync2 = q.sync1;
    d.pulse = 1'b0;
    if (q.sync2 != q.level)
    begin
      if (q.cnt == 20'(DB_CYCLES - 1))
      begin
        d.level = q.sync2;
        d.cnt = 20'h00000;
        d.pulse = q.sync2; // Only closure counts, so release bounce is harmless
      end
      else
      begin
        d.cnt = q.cnt + 20'h00001;
      end
    end
    else
    begin
      d.cnt = 20'h00000; // Bounce back restarts the settle window
    end
  end

  // State register
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      q <= '0;
    end
    else if (clk_en)
    begin
      q <= d;
    end
  end

  assign pls.pulse = q.pulse;
  assign pls.level = q.level;

endmodule: pec_debounce

`default_nettype wire

// ===== core/pec_top.sv
// The AHB-Lite interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "pec_consts.svh"

// Behaviour
// - Each pulse adds one to a 32-bit total, wrapping from all ones to zero.
// - Counting continues while the logger sleeps; no pulse is dropped.
// - Total survives main battery swap, held by its own retention reset.
// - With midnight clear enabled, the midnight tick zeroes the total.
// - A software command overwrites the total with zero.
// - Each log tick stores pulses since the last tick, then restarts that count.
// - The running interval count grows per pulse; only the tick value is stored.
// - Rate comes from time between the last two pulses, scaled to one hour.
// - Counts convert to units by a units-per-pulse factor, defaulting to one.
// - A pulse arriving in sleep is captured and raises a wake request.
module pec_top #(
  parameter int DB_CYCLES = `PEC_DB_CYCLES,
  parameter int MS_CYCLES = `PEC_MS_CYCLES
) (
  input wire logic hclk, // Logger clock
  input wire logic hresetn, // Async reset, active low
  input wire logic retain_rstn, // Retention reset of the total, active low
  input wire logic clk_en, // Freezes all state while low
  input wire logic hsel, // AHB slave select
  input wire logic [31:0] haddr, // AHB address
  input wire logic [1:0] htrans, // AHB transfer type
  input wire logic hwrite, // AHB write
  input wire logic [2:0] hsize, // AHB size
  input wire logic [31:0] hwdata, // AHB write data
  input wire logic hready, // AHB bus ready
  output logic [31:0] hrdata, // AHB read data
  output logic hreadyout, // AHB slave ready
  output logic hresp, // AHB response, always OKAY
  input wire logic pulse_pin, // Switch input pin
  input wire logic sleep_in, // Logger is asleep
  input wire logic log_tick, // Log interval boundary strobe
  input wire logic midnight_tick, // Midnight strobe
  output logic irq, // Level interrupt
  output logic wake_req, // Wake pulse for a pulse in sleep
  output logic log_event // Log request on total change
);

  // One hour in milliseconds, sized to the divider numerator
  localparam logic [53:0] MS_HOUR = 54'(`PEC_MS_PER_HOUR);

  pec_pkg::pec_st_t s_q;
  pec_pkg::pec_st_t s_d;
  logic [31:0] total_q;
  logic [31:0] total_d;
  logic [4:0] ev;
  logic [4:0] w1c;
  logic clr_cmd;
  logic clr_any;
  logic pulse;
  logic ms_tick;
  logic addr_ok;
  logic [32:0] rem_sh;
  logic ge;
  logic [63:0] units_prod;

  pec_pulse_if pls ();

  // Sync and debounce of the pin; the only path from pin to counter
  // Settle time trades fast tips for immunity to reed chatter
  pec_debounce #(
    .DB_CYCLES(DB_CYCLES)
  ) u_db (
    .hclk(hclk),
    .hresetn(hresetn),
    .clk_en(clk_en),
    .pin_in(pulse_pin),
    .pls(pls)
  );

  // Debounced closure strobe, one cycle per counted tip
  assign pulse = pls.pulse;

  // Whole next state; bus decode comes last so reads see this cycle's update
  always_comb
  begin
    s_d = s_q;
    total_d = total_q;
    ev = 5'h00;
    w1c = 5'h00;
    clr_cmd = 1'b0;
    clr_any = 1'b0;
    ms_tick = 1'b0;
    addr_ok = 1'b0;
    rem_sh = 33'h000000000;
    ge = 1'b0;
    units_prod = 64'h0000000000000000;
    s_d.wake = 1'b0;
    s_d.log_evt = 1'b0;
    s_d.rdy = 1'b1;

    // Data phase of a write: apply the word latched in the address phase
    if (s_q.wr_pend && hready)
    begin
      case (s_q.wr_addr)
        `PEC_OFS_CTRL:
        begin
          s_d.ctrl = hwdata[1:0];
        end
        `PEC_OFS_CMD:
        begin
          clr_cmd = hwdata[`PEC_CMD_CLEAR];
        end
        `PEC_OFS_UPP:
        begin
          s_d.upp = hwdata;
        end
        `PEC_OFS_IRQ_STAT:
        begin
          w1c = hwdata[4:0];
        end
        `PEC_OFS_IRQ_MASK:
        begin
          s_d.irq_mask = hwdata[4:0];
        end
        default:
        begin
          // Read-only and unmapped words ignore writes
        end
      endcase
    end

    // Total; no sleep gating anywhere, so it counts in sleep too
    if (pulse)
    begin
      total_d = total_q + 32'h00000001; // Natural wrap at all ones
      ev[`PEC_IRQ_PULSE] = 1'b1;
      ev[`PEC_IRQ_WRAP] = (total_q == 32'hFFFFFFFF);
    end
    clr_any = clr_cmd;
    if (midnight_tick && s_q.ctrl[`PEC_CTRL_MIDNIGHT])
    begin
      clr_any = 1'b1;
    end
    if (clr_any)
    begin
      // A pulse in the clearing cycle is kept as the first new count
      total_d = pulse ? 32'h00000001 : 32'h00000000;
    end

    // Log-each-change request on any change of the total
    if ((total_d != total_q) && s_q.ctrl[`PEC_CTRL_LOG_CHG])
    begin
      s_d.log_evt = 1'b1;
      ev[`PEC_IRQ_CHANGE] = 1'b1;
    end

    // Wake the logger for a pulse caught while asleep
    if (pulse && sleep_in)
    begin
      s_d.wake = 1'b1;
    end

    // Interval quantity; a pulse on the tick belongs to the closing interval
    if (log_tick)
    begin
      s_d.qty_log = s_q.qty_run + {31'h00000000, pulse};
      s_d.qty_run = 32'h00000000;
      units_prod = {32'h00000000, s_d.qty_log} * {32'h00000000, s_q.upp};
      s_d.qty_units = units_prod[47:16]; // 16.16 factor, fraction dropped
      ev[`PEC_IRQ_LOGGED] = 1'b1;
    end
    else if (pulse)
    begin
      s_d.qty_run = s_q.qty_run + 32'h00000001; // Running view only
    end

    // Millisecond timebase; elapsed time saturates on a long dry spell
    if (s_q.ms_div == 20'(MS_CYCLES - 1))
    begin
      s_d.ms_div = 20'h00000;
      ms_tick = 1'b1;
    end
    else
    begin
      s_d.ms_div = s_q.ms_div + 20'h00001;
    end
    if (ms_tick && (s_q.ms_since != 32'hFFFFFFFF))
    begin
      s_d.ms_since = s_q.ms_since + 32'h00000001;
    end

    // Rate divider: one quotient bit per cycle, restoring division
    unique case (s_q.div_st)
      pec_pkg::DIV_IDLE:
      begin
      end
      pec_pkg::DIV_RUN:
      begin
        rem_sh = {s_q.div_rem[31:0], s_q.div_num[53]};
        ge = (rem_sh >= {1'b0, s_q.div_den});
        s_d.div_rem = ge ? (rem_sh - {1'b0, s_q.div_den}) : rem_sh;
        s_d.div_num = {s_q.div_num[52:0], ge};
        s_d.div_cnt = s_q.div_cnt - 6'h01;
        if (s_q.div_cnt == 6'h01)
        begin
          // Quotient too wide for 32 bits is clamped, not wrapped
          s_d.rate = (|s_d.div_num[53:32]) ? 32'hFFFFFFFF :
                     s_d.div_num[31:0];
          s_d.div_st = pec_pkg::DIV_IDLE;
          ev[`PEC_IRQ_RATE] = 1'b1;
        end
      end
    endcase

    // A new pulse closes the gap and restarts the division at once
    if (pulse)
    begin
      s_d.ms_since = 32'h00000000;
      s_d.ms_div = 20'h00000;
      s_d.have_prev = 1'b1;
      if (s_q.have_prev)
      begin
        // Gaps under one millisecond count as one to avoid division by zero
        s_d.interval = (s_q.ms_since == 32'h00000000) ? 32'h00000001 :
                       s_q.ms_since;
        s_d.div_den = s_d.interval;
        s_d.div_num = {22'h000000, s_q.upp} * MS_HOUR;
        s_d.div_rem = 33'h000000000;
        s_d.div_cnt = 6'h36;
        s_d.div_st = pec_pkg::DIV_RUN;
      end
    end

    // Sticky status; a new event beats a clear in the same cycle
    s_d.irq_stat = (s_q.irq_stat & ~w1c) | ev;
    s_d.irq = |(s_d.irq_stat & s_d.irq_mask);

    // Address phase: latch writes, prepare read data from next state
    s_d.wr_pend = 1'b0;
    if (hsel && htrans[1] && hready)
    begin
      addr_ok = (haddr[1:0] == 2'h0) && (haddr[31:8] == 24'h000000);
      s_d.wr_pend = hwrite && addr_ok;
      s_d.wr_addr = haddr[7:0];
      s_d.hrdata = 32'h00000000;
      if (!hwrite && addr_ok)
      begin
        case (haddr[7:0])
          `PEC_OFS_CTRL:
          begin
            s_d.hrdata = {30'h00000000, s_d.ctrl};
          end
          `PEC_OFS_TOTAL:
          begin
            s_d.hrdata = total_d;
          end
          `PEC_OFS_QTY_RUN:
          begin
            s_d.hrdata = s_d.qty_run;
          end
          `PEC_OFS_QTY_LOG:
          begin
            s_d.hrdata = s_d.qty_log;
          end
          `PEC_OFS_UPP:
          begin
            s_d.hrdata = s_d.upp;
          end
          `PEC_OFS_INTERVAL:
          begin
            s_d.hrdata = s_d.interval;
          end
          `PEC_OFS_RATE:
          begin
            s_d.hrdata = s_d.rate;
          end
          `PEC_OFS_QTY_UNITS:
          begin
            s_d.hrdata = s_d.qty_units;
          end
          `PEC_OFS_IRQ_STAT:
          begin
            s_d.hrdata = {27'h0000000, s_d.irq_stat};
          end
          `PEC_OFS_IRQ_MASK:
          begin
            s_d.hrdata = {27'h0000000, s_d.irq_mask};
          end
          default:
          begin
            s_d.hrdata = 32'h00000000; // Unmapped and command words read zero
          end
        endcase
      end
    end
  end

  // Core state on the logger reset
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s_q <= '0;
      s_q.ctrl <= `PEC_CTRL_RST;
      s_q.upp <= `PEC_UPP_RST;
      s_q.irq_mask <= `PEC_MASK_RST;
      s_q.div_st <= pec_pkg::DIV_IDLE;
      s_q.rdy <= 1'b1;
    end
    else if (clk_en)
    begin
      s_q <= s_d;
    end
  end

  // Total sits on the retained supply, so only its own reset clears it
  always_ff @(posedge hclk or negedge retain_rstn)
  begin
    if (!retain_rstn)
    begin
      total_q <= 32'h00000000;
    end
    else if (clk_en)
    begin
      total_q <= total_d;
    end
  end

  // Outputs straight from flops, apart from hresp tied to OKAY
  assign hrdata = s_q.hrdata;
  assign hreadyout = s_q.rdy;
  assign hresp = 1'b0;
  assign irq = s_q.irq;
  assign wake_req = s_q.wake;
  assign log_event = s_q.log_evt;

  // Size is not checked: only whole words are supported
  logic unused_ok;
  assign unused_ok = ^{hsize, pls.level};

endmodule: pec_top

`default_nettype wire

// ===== sim/pec_sensor_model.sv
`timescale 1ns/1ns
`default_nettype none

// Reed contact between the pulse pin and the supply; pull-down when open
module pec_sensor_model (
  input wire logic hclk, // Logger clock
  output logic pin // Contact side of the pulse input
);
  initial pin = 1'h0;

  // One bucket tip: contact chatter, a firm closure, then open
  // Open contact reads low through the pull-down, never a stale level
  task automatic tip(input int hold);
    repeat (2)
    begin
      pin <= 1'h1;
      @(posedge hclk);
      pin <= 1'h0;
      @(posedge hclk);
    end
    pin <= 1'h1;
    repeat (hold) @(posedge hclk);
    pin <= 1'h0;
    repeat (20) @(posedge hclk);
  endtask: tip
endmodule: pec_sensor_model

`default_nettype wire

// ===== sim/pec_monitor.sv
`timescale 1ns/1ns
`default_nettype none

// Pin-level checks on the pulse counter block
module pec_monitor #(
  parameter int DB_CYCLES = 4, // Debounce length
  parameter int MS_CYCLES = 10 // Millisecond divider
) (
  input wire logic hclk, // Clock
  input wire logic hresetn, // Reset, active low
  input wire logic clk_en, // Run enable
  input wire logic hsel, // Slave select
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write
  input wire logic hready, // Bus ready
  input wire logic [31:0] hrdata, // Read data
  input wire logic hreadyout, // Slave ready
  input wire logic hresp, // Response
  input wire logic pulse_pin, // Switch pin
  input wire logic sleep_in, // Asleep
  input wire logic irq, // Interrupt
  input wire logic wake_req, // Wake pulse
  input wire logic log_event // Change log pulse
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // Firm closure while asleep; chatter shorter than this never matches
  sequence sleep_closure;
    (sleep_in && clk_en && !pulse_pin) ##1
      (sleep_in && clk_en && pulse_pin) [*6];
  endsequence

  resp_okay_a: assert property (hresp == 1'h0)
    else $error("response not OKAY");
  ready_high_a: assert property ($past(hresetn) |-> hreadyout)
    else $error("slave not ready after reset");
  rdata_hold_a: assert property (
    !$stable(hrdata) |-> $past(hsel && htrans[1] && hready))
    else $error("read data moved without a transfer");
  irq_clear_a: assert property (
    $fell(irq) |-> $past(hsel && htrans[1] && hwrite && hready, 2))
    else $error("interrupt fell without a register write");
  wake_on_pulse_a: assert property (
    sleep_closure |-> ##[0:8] wake_req)
    else $error("pulse in sleep gave no wake");
  wake_once_a: assert property (wake_req |=> !wake_req [*6])
    else $error("one closure counted twice");
  wake_awake_a: assert property (!sleep_in [*3] |-> !wake_req)
    else $error("wake while awake");
  log_pulse_a: assert property (log_event |=> !log_event)
    else $error("log event longer than one cycle");
endmodule: pec_monitor

bind pec_top pec_monitor #(.DB_CYCLES(DB_CYCLES), .MS_CYCLES(MS_CYCLES))
  u_mon (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .pulse_pin(pulse_pin),
  .sleep_in(sleep_in), .irq(irq), .wake_req(wake_req),
  .log_event(log_event));

`default_nettype wire

// ===== sim/test_pulse_event_counter.sv
`timescale 1ns/1ns
`default_nettype none
`include "pec_consts.svh"

module test_pulse_event_counter;
  logic hclk = 1'h0;
  logic hresetn = 1'h0;
  logic retain_rstn = 1'h0;
  logic clk_en = 1'h1;
  logic hsel = 1'h0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'h0;
  logic [31:0] hwdata = 32'h0;
  logic [2:0] hsize = 3'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hready;
  logic pulse_pin;
  logic sleep_in = 1'h0;
  logic log_tick = 1'h0;
  logic midnight_tick = 1'h0;
  logic irq;
  logic wake_req;
  logic log_event;
  int failures = 0;
  int n_compared = 0;
  int cycles = 0;
  int n_wake = 0;
  int n_log = 0;
  logic hresp;

  always #10 hclk = ~hclk;
  assign hready = hreadyout;

  pec_top #(.DB_CYCLES(4), .MS_CYCLES(10)) dut (.hclk(hclk),
    .hresetn(hresetn), .retain_rstn(retain_rstn), .clk_en(clk_en),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .pulse_pin(pulse_pin),
    .sleep_in(sleep_in), .log_tick(log_tick), .midnight_tick(midnight_tick),
    .irq(irq), .wake_req(wake_req), .log_event(log_event));

  pec_sensor_model sensor (.hclk(hclk), .pin(pulse_pin));

  // Pulse outputs last one cycle, so they are tallied at every edge
  always @(posedge hclk)
  begin
    cycles++;
    if (wake_req === 1'h1) n_wake++;
    if (log_event === 1'h1) n_log++;
    if (cycles == 20000)
    begin
      failures++;
      $display("ERROR %0t: run did not finish", $time);
      final_report();
    end
  end

  task automatic final_report();
    $display("failures %0d n_compared %0d", failures, n_compared);
    if (failures == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask: final_report

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask: check

  // One single transfer; the bus decides how long each phase lasts
  task automatic bus(input logic w, input logic [31:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'h1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    hsize <= 3'h2;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    rd = hrdata;
  endtask: bus

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] unused;
    bus(1'h1, a, d, unused);
  endtask: wr

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] got;
    bus(1'h0, a, 32'h0, got);
    check(got, exp);
  endtask: rd_chk

  // Strobes last exactly one cycle, as the timebase gives them
  task automatic strobe(input logic midnight);
    if (midnight) midnight_tick <= 1'h1;
    else log_tick <= 1'h1;
    @(posedge hclk);
    midnight_tick <= 1'h0;
    log_tick <= 1'h0;
    @(posedge hclk);
  endtask: strobe

  initial
  begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'h1;
    retain_rstn <= 1'h1;
    repeat (2) @(posedge hclk);
    rd_chk(`PEC_OFS_CTRL, 32'h0);
    rd_chk(`PEC_OFS_UPP, 32'h0001_0000);
    rd_chk(`PEC_OFS_IRQ_MASK, 32'h0);
    check(hresp, 1'h0);
    wr(32'h0000_002C, 32'hFFFF_FFFF);
    rd_chk(32'h0000_002C, 32'h0);
    rd_chk(32'h0000_0009, 32'h0);
    // Two tips while asleep; small factor keeps the rate unsaturated
    wr(`PEC_OFS_UPP, 32'h0000_0100);
    sleep_in <= 1'h1;
    sensor.tip(20);
    repeat (180) @(posedge hclk);
    sensor.tip(20);
    repeat (60) @(posedge hclk);
    check(n_wake, 2);
    rd_chk(`PEC_OFS_TOTAL, 32'h2);
    rd_chk(`PEC_OFS_QTY_RUN, 32'h2);
    // Closures 224 cycles apart: 22 whole milliseconds of 10 cycles
    rd_chk(`PEC_OFS_INTERVAL, 32'h16);
    // 0x100 * 3600000 / 22, fraction dropped
    rd_chk(`PEC_OFS_RATE, 32'h027F_345D);
    wr(`PEC_OFS_UPP, 32'h0002_0000);
    strobe(1'h0);
    rd_chk(`PEC_OFS_QTY_LOG, 32'h2);
    rd_chk(`PEC_OFS_QTY_RUN, 32'h0);
    rd_chk(`PEC_OFS_QTY_UNITS, 32'h4);
    // Events latch even while masked; the line stays low until unmasked
    rd_chk(`PEC_OFS_IRQ_STAT, 32'h13);
    check(irq, 1'h0);
    wr(`PEC_OFS_IRQ_MASK, 32'h1);
    repeat (2) @(posedge hclk);
    check(irq, 1'h1);
    wr(`PEC_OFS_IRQ_STAT, 32'h1F);
    repeat (2) @(posedge hclk);
    check(irq, 1'h0);
    rd_chk(`PEC_OFS_IRQ_STAT, 32'h0);
    // Awake, change logging on, then software clear
    sleep_in <= 1'h0;
    wr(`PEC_OFS_CTRL, 32'h2);
    sensor.tip(20);
    check(n_wake, 2);
    check(n_log, 1);
    rd_chk(`PEC_OFS_TOTAL, 32'h3);
    wr(`PEC_OFS_CMD, 32'h1);
    rd_chk(`PEC_OFS_TOTAL, 32'h0);
    check(n_log, 2);
    sensor.tip(20);
    strobe(1'h1);
    rd_chk(`PEC_OFS_TOTAL, 32'h1);
    wr(`PEC_OFS_CTRL, 32'h1);
    strobe(1'h1);
    rd_chk(`PEC_OFS_TOTAL, 32'h0);
    // Clock enable low freezes the sync flops, so a tip then is not seen
    clk_en <= 1'h0;
    sensor.tip(20);
    clk_en <= 1'h1;
    rd_chk(`PEC_OFS_TOTAL, 32'h0);
    sensor.tip(20);
    // Main reset alone must leave the retained total in place
    hresetn <= 1'h0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'h1;
    repeat (2) @(posedge hclk);
    rd_chk(`PEC_OFS_TOTAL, 32'h1);
    rd_chk(`PEC_OFS_CTRL, 32'h0);
    sensor.tip(20);
    rd_chk(`PEC_OFS_TOTAL, 32'h2);
    // Only the retention reset clears the retained total
    retain_rstn <= 1'h0;
    @(posedge hclk);
    retain_rstn <= 1'h1;
    @(posedge hclk);
    rd_chk(`PEC_OFS_TOTAL, 32'h0);
    final_report();
  end
endmodule: test_pulse_event_counter

`default_nettype wire
